// file: hw/bmon_pkg.sv
// package: field layouts, reset values and command carriers for the config/control bank
package bmon_pkg;

    // ----------------------------------------------------------------
    // configuration register layout
    // ----------------------------------------------------------------
    localparam int CFG_OVCH_LSB = 14;
    localparam int CFG_OVDS_LSB = 12;
    localparam int CFG_OVCU_LSB = 10;
    localparam int CFG_CGTH_LSB = 8;
    localparam int CFG_CELLS_BIT = 7;
    localparam int CFG_CGDIS_BIT = 6;
    localparam logic [15:0] CFG_USED_MASK = 16'hffc0;
    // blank-part contents of the shadow store, used until the first store
    localparam logic [15:0] SHADOW_BLANK = 16'h33c0;

    // ----------------------------------------------------------------
    // control register layout
    // ----------------------------------------------------------------
    localparam int CTL_BAL_LSB = 12;
    localparam int CTL_DFET_BIT = 11;
    localparam int CTL_CFET_BIT = 10;
    localparam int CTL_GAIN_LSB = 8;
    localparam int CTL_SLEEP_BIT = 7;
    localparam logic [15:0] CTL_USED_MASK = 16'hff80;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam int STORE_CYCLES = 4;

    typedef struct packed {
        logic [1:0] overcharge_threshold_sel;
        logic [1:0] overdischarge_threshold_sel;
        logic [1:0] overcurrent_threshold_sel;
        logic [1:0] charge_gate_threshold_sel;
        logic cell_count_select;
        logic charge_gate_disable;
    } cfg_fields_t;

    typedef struct packed {
        logic write_configuration_cmd;
        logic write_control_cmd;
        logic write_enable_cmd;
        logic array_write_cmd;
        logic [15:0] data;
    } host_cmd_t;

    typedef struct packed {
        logic [3:0] balance_output_pins;
        logic discharge_fet_pin;
        logic charge_fet_pin;
        logic [1:0] current_gain_sel;
        logic sleep_req;
    } pin_drive_t;

endpackage : bmon_pkg

// file: hw/shadow_store.sv
// nonvolatile shadow of the configuration register, modelled as a held word
module shadow_store
    import bmon_pkg::*;
(
    input wire logic mclk,
    input wire logic store_go,
    input wire logic [15:0] store_data,
    output logic [15:0] recall_data
);
    logic [15:0] cell_q;
    logic [15:0] cell_d;
    logic init_q;

    always_comb
    begin
        // an unknown flag after power-up must fall into the blank branch
        if (init_q)
        begin
            cell_d = cell_q;
            if (store_go)
                cell_d = store_data;
        end
        else
            cell_d = SHADOW_BLANK;
    end

    // no reset: contents must survive every device reset (power cycle)
    always_ff @(posedge mclk)
    begin
        cell_q <= cell_d;
        init_q <= 1'b1;
        recall_data <= cell_d;
    end
endmodule : shadow_store

// file: hw/bmon_cfg_ctrl_regs.sv
// configuration and control register bank of the pack monitor
// Function
// - config is 16 bits: four 2-bit thresholds, cell count, charge-gate disable; 5:0 ignored
// - overcharge code selects 4.20, 4.25, 4.30, 4.35 V
// - overdischarge code selects 1.95-2.25 V (four-cell) or 2.25-2.55 V (three-cell)
// - overcurrent code selects 0.075, 0.100, 0.125, 0.150 V sense
// - charge-gate bit 0 enables low-cell charge block, 1 disables it
// - charge-gate threshold code selects 0.5, 0.80, 1.10, 1.40 V
// - cell count bit 1 means four cells; host keeps 0 on three-cell parts
// - power-up recalls shadow bits into the config register
// - config write changes only the volatile copy
// - write enable then array write stores config into shadow
// - unsaved config is lost over a power cycle
// - control is 16 volatile bits: balance, FETs, gain, sleep
// - control clears on power-up and on sleep exit
// - control bits 15:10 each switch their own pin
// - gain code selects x10, x25, x80, x160
// - FET bit 1 drives pin low (FET on), 0 drives it high
// - FET pins hold during protection mode, update after it
// - sleep bit 1 enters sleep if supply below threshold
module bmon_cfg_ctrl_regs
    import bmon_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input host_cmd_t cmd,
    input wire logic protect_mode,
    input wire logic supply_below_sleep,
    input wire logic sleep_exit,
    output logic [15:0] cfg_word,
    output cfg_fields_t cfg_fields,
    output logic [15:0] ctl_word,
    output pin_drive_t pins,
    output logic sleep_enter,
    output logic store_busy,
    output logic [1:0] uv_sel_code
);
    // ----------------------------------------------------------------
    // input synchronisers for pins from the analog side
    // ----------------------------------------------------------------
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end
        else
        begin
            sync1_q <= {protect_mode, supply_below_sleep, sleep_exit};
            sync2_q <= sync1_q;
        end
    end
    logic prot_s;
    logic below_s;
    logic wake_s;
    assign prot_s = sync2_q[2];
    assign below_s = sync2_q[1];
    assign wake_s = sync2_q[0];

    // ----------------------------------------------------------------
    // shadow store and state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_RECALL, ST_RUN, ST_STORE} state_t;
    state_t state_q;
    state_t state_d;
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic [15:0] ctl_q;
    logic [15:0] ctl_d;
    logic wen_q;
    logic wen_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [5:0] fet_q;
    logic [5:0] fet_d;
    logic wake_q;
    logic [15:0] recall_data;
    logic store_go;

    shadow_store u_shadow (
        .mclk(mclk),
        .store_go(store_go),
        .store_data(cfg_q),
        .recall_data(recall_data)
    );
    assign store_go = (state_q == ST_STORE) && (cnt_q == 3'(STORE_CYCLES - 1));

    always_comb
    begin
        state_d = state_q;
        cfg_d = cfg_q;
        ctl_d = ctl_q;
        wen_d = wen_q;
        cnt_d = cnt_q;
        fet_d = fet_q;
        case (state_q)
            ST_RECALL:
            begin
                cfg_d = recall_data & CFG_USED_MASK;
                state_d = ST_RUN;
            end
            ST_RUN:
            begin
                if (cmd.write_configuration_cmd)
                    cfg_d = cmd.data & CFG_USED_MASK;
                if (cmd.write_enable_cmd)
                    wen_d = 1'b1;
                if (cmd.array_write_cmd && wen_q)
                begin
                    wen_d = 1'b0;
                    cnt_d = 3'h0;
                    state_d = ST_STORE;
                end
            end
            ST_STORE:
            begin
                cnt_d = cnt_q + 3'h1;
                if (store_go)
                    state_d = ST_RUN;
            end
            default: state_d = ST_RECALL;
        endcase
        // reserved bits 6:5 are stored as the host wrote them; 4:0 dropped
        if (cmd.write_control_cmd && state_q != ST_RECALL)
            ctl_d = cmd.data & 16'hffe0;
        if (wake_s && !wake_q)
            ctl_d = CTL_RESET;
        // FET pins follow their bits only outside protection mode
        if (!prot_s)
            fet_d = ctl_q[15:10];
        else
            fet_d = {ctl_q[15:12], fet_q[1:0]};
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state_q <= ST_RECALL;
            cfg_q <= 16'h0000;
            ctl_q <= CTL_RESET;
            wen_q <= 1'b0;
            cnt_q <= 3'h0;
            fet_q <= 6'h00;
            wake_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            ctl_q <= ctl_d;
            wen_q <= wen_d;
            cnt_q <= cnt_d;
            fet_q <= fet_d;
            wake_q <= wake_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign cfg_word = cfg_q;
    assign ctl_word = ctl_q;
    assign store_busy = (state_q != ST_RUN);
    // thresholds are decoded in the analog block; codes pass unchanged
    assign cfg_fields.overcharge_threshold_sel = cfg_q[CFG_OVCH_LSB +: 2];
    assign cfg_fields.overdischarge_threshold_sel = cfg_q[CFG_OVDS_LSB +: 2];
    assign cfg_fields.overcurrent_threshold_sel = cfg_q[CFG_OVCU_LSB +: 2];
    assign cfg_fields.charge_gate_threshold_sel = cfg_q[CFG_CGTH_LSB +: 2];
    assign cfg_fields.cell_count_select = cfg_q[CFG_CELLS_BIT];
    assign cfg_fields.charge_gate_disable = cfg_q[CFG_CGDIS_BIT];
    // undervoltage code is the overdischarge field unchanged, with no offset in three-cell mode
    assign uv_sel_code = cfg_q[CFG_OVDS_LSB +: 2];
    // balance high = on; FET bit high = pin low
    assign pins.balance_output_pins = fet_q[5:2];
    assign pins.discharge_fet_pin = ~fet_q[1];
    assign pins.charge_fet_pin = ~fet_q[0];
    assign pins.current_gain_sel = ctl_q[CTL_GAIN_LSB +: 2];
    assign pins.sleep_req = ctl_q[CTL_SLEEP_BIT];
    assign sleep_enter = ctl_q[CTL_SLEEP_BIT] && below_s;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_cfg_write_takes: assert property (@(posedge mclk) disable iff (!rst_b)
        (state_q == ST_RUN && cmd.write_configuration_cmd)
        |=> cfg_q == ($past(cmd.data) & CFG_USED_MASK))
        else $error("config write not taken");
    a_store_needs_wen: assert property (@(posedge mclk) disable iff (!rst_b)
        (state_q == ST_RUN && cmd.array_write_cmd && !wen_q) |=> state_q == ST_RUN)
        else $error("store without write enable");
    a_store_ends: assert property (@(posedge mclk) disable iff (!rst_b)
        (state_q == ST_RUN && cmd.array_write_cmd && wen_q)
        |=> state_q == ST_STORE ##4 state_q == ST_RUN)
        else $error("store did not finish");
    a_recall_loads: assert property (@(posedge mclk) disable iff (!rst_b)
        state_q == ST_RECALL |=> cfg_q == ($past(recall_data) & CFG_USED_MASK))
        else $error("recall not loaded");
    a_ctl_write: assert property (@(posedge mclk) disable iff (!rst_b)
        (cmd.write_control_cmd && state_q != ST_RECALL && !(wake_s && !wake_q))
        |=> ctl_q == ($past(cmd.data) & 16'hffe0))
        else $error("control write lost");
    a_wake_clears: assert property (@(posedge mclk) disable iff (!rst_b)
        (wake_s && !wake_q) |=> ctl_q == CTL_RESET)
        else $error("control not cleared on wake");
    a_fet_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        prot_s |=> $stable(pins.charge_fet_pin) && $stable(pins.discharge_fet_pin))
        else $error("fet pin moved in protection");
    a_fet_follow: assert property (@(posedge mclk) disable iff (!rst_b)
        !prot_s |=> pins.charge_fet_pin == !$past(ctl_q[CTL_CFET_BIT])
            && pins.discharge_fet_pin == !$past(ctl_q[CTL_DFET_BIT]))
        else $error("fet pin does not follow its bit");
    a_sleep_gate: assert property (@(posedge mclk) disable iff (!rst_b)
        sleep_enter == (below_s && ctl_q[CTL_SLEEP_BIT]))
        else $error("sleep without cause");
endmodule : bmon_cfg_ctrl_regs

// file: verif/host_model.sv
// host-side command source for the config/control bank
module host_model
    import bmon_pkg::*;
(
    input wire logic mclk,
    output host_cmd_t cmd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cmd = '0;

    // ----------------------------------------------------------------
    // one-cycle command pulse; op 0 cfg, 1 ctl, 2 enable, 3 array write
    // ----------------------------------------------------------------
    task automatic send(input int op, input logic [15:0] d, input int gap);
        host_cmd_t c;
        c = '0;
        c.data = d;
        if (op == 1)
            c.data[6:5] = 2'b00;
        c.write_configuration_cmd = (op == 0);
        c.write_control_cmd = (op == 1);
        c.write_enable_cmd = (op == 2);
        c.array_write_cmd = (op == 3);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        cmd <= c;
        @(posedge mclk);
        // released data must not look valid, so it flips
        cmd <= '{default: 1'b0, data: ~c.data};
    endtask : send
endmodule : host_model

// file: verif/bmon_cfg_ctrl_regs_bench.sv
// self-checking bench for the config/control register bank
module bmon_cfg_ctrl_regs_bench
    import bmon_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, rst_b, protect_mode, supply_below_sleep, sleep_exit;
    host_cmd_t cmd;
    logic [15:0] cfg_word, ctl_word, a, b;
    cfg_fields_t cfg_fields;
    pin_drive_t pins;
    logic sleep_enter, store_busy;
    logic [1:0] uv_sel_code;
    int error_cnt = 0;
    int checked = 0;
    int seed = 32'hb562d230;
    logic [15:0] exp_q[$];
    int kind_q[$];
    event look;

    host_model i_host (.mclk(mclk), .cmd(cmd));
    bmon_cfg_ctrl_regs i_bmon_cfg_ctrl_regs (.mclk(mclk), .rst_b(rst_b), .cmd(cmd),
        .protect_mode(protect_mode), .supply_below_sleep(supply_below_sleep),
        .sleep_exit(sleep_exit), .cfg_word(cfg_word), .cfg_fields(cfg_fields),
        .ctl_word(ctl_word), .pins(pins), .sleep_enter(sleep_enter),
        .store_busy(store_busy), .uv_sel_code(uv_sel_code));

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // result watcher: kind 0 cfg, 1 ctl, 2 pins, 3 fields, 4 uv, 5 sleep
    // ----------------------------------------------------------------
    task automatic judge(input logic [15:0] got, input logic [15:0] e, input string what);
        checked++;
        if (got !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, e);
        end
    endtask : judge

    task automatic cmp_cfg(input logic [15:0] e);
        judge(cfg_word, e, "config word");
    endtask : cmp_cfg

    task automatic cmp_ctl(input logic [15:0] e);
        judge(ctl_word, e, "control word");
    endtask : cmp_ctl

    task automatic cmp_pins(input logic [15:0] e);
        judge({7'h00, pins}, e, "pin drive");
    endtask : cmp_pins

    task automatic cmp_fields(input logic [15:0] e);
        judge({6'h00, cfg_fields}, e, "config fields");
    endtask : cmp_fields

    task automatic cmp_uv(input logic [15:0] e);
        judge({14'h0000, uv_sel_code}, e, "undervoltage code");
    endtask : cmp_uv

    task automatic cmp_sleep(input logic [15:0] e);
        judge({15'h0000, sleep_enter}, e, "sleep entry");
    endtask : cmp_sleep

    task automatic cmp(input int k, input logic [15:0] e);
        case (k)
            0: cmp_cfg(e);
            1: cmp_ctl(e);
            2: cmp_pins(e);
            3: cmp_fields(e);
            4: cmp_uv(e);
            default: cmp_sleep(e);
        endcase
    endtask : cmp

    always @(look)
    begin
        while (kind_q.size() > 0)
            cmp(kind_q.pop_front(), exp_q.pop_front());
    end

    task automatic note(input int k, input logic [15:0] e);
        kind_q.push_back(k);
        exp_q.push_back(e);
    endtask : note

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
        ->look;
        // let the watcher drain before the caller queues new notes
        #1;
    endtask : step

    task automatic close_out();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    task automatic wait_busy(input logic v);
        repeat (20)
        begin
            #1;
            if (store_busy === v)
                return;
            @(posedge mclk);
        end
        error_cnt++;
        close_out();
    endtask : wait_busy

    task automatic wr_cfg(input logic [15:0] d, input int gap);
        i_host.send(0, d, gap);
        note(0, d & 16'hffc0);
        note(3, {6'h00, d[15:6]});
        note(4, {14'h0000, d[13:12]});
        step(3);
    endtask : wr_cfg

    // pins expected only when no protection is pending
    task automatic wr_ctl(input logic [15:0] d, input int gap, input logic live);
        i_host.send(1, d, gap);
        note(1, d & 16'hff80);
        if (live)
            note(2, {7'h00, d[15:12], ~d[11:10], d[9:7]});
        step(3);
    endtask : wr_ctl

    task automatic power_cycle();
        rst_b <= 1'b0;
        step(2);
        rst_b <= 1'b1;
        step(3);
    endtask : power_cycle

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        protect_mode = 1'b0;
        supply_below_sleep = 1'b0;
        sleep_exit = 1'b0;
        step(6);
        rst_b <= 1'b1;
        note(0, SHADOW_BLANK);
        note(1, 16'h0000);
        note(2, 16'h0018);
        step(3);
        for (int i = 0; i < 4; i++)
        begin
            a = $random(seed);
            wr_cfg({{4{i[1:0]}}, a[7:0]}, i);
            b = $random(seed);
            wr_ctl({b[15:10], i[1:0], 1'b0, b[6:0]}, 3 - i, 1'b1);
        end
        supply_below_sleep <= 1'b1;
        wr_ctl(16'h0c80, 0, 1'b1);
        note(5, 16'h0001);
        step(3);
        protect_mode <= 1'b1;
        step(4);
        wr_ctl(16'hf300, 0, 1'b0);
        note(2, 16'h01e6);
        step(1);
        protect_mode <= 1'b0;
        note(2, 16'h01fe);
        step(6);
        sleep_exit <= 1'b1;
        step(5);
        note(1, 16'h0000);
        note(2, 16'h0018);
        note(5, 16'h0000);
        sleep_exit <= 1'b0;
        step(2);
        wr_cfg(16'h5a80, 0);
        i_host.send(2, 16'h0000, 1);
        i_host.send(3, 16'h1234, 0);
        wait_busy(1'b1);
        i_host.send(0, 16'hffff, 0);
        wait_busy(1'b0);
        note(0, 16'h5a80);
        step(1);
        wr_cfg(16'ha5c0, 0);
        power_cycle();
        note(0, 16'h5a80);
        step(1);
        wr_cfg(16'h0f40, 0);
        i_host.send(3, 16'h00ff, 0);
        step(8);
        power_cycle();
        note(0, 16'h5a80);
        step(2);
        close_out();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        close_out();
    end
endmodule : bmon_cfg_ctrl_regs_bench
